// [logic/psts_pkg.sv]
package psts_pkg;

  // timing: one clock cycle and the longest allowed sequence run
  localparam int unsigned CLK_PERIOD_NS   = 25;
  localparam int unsigned SEQ_MAX_TIME_S  = 1;
  localparam int unsigned NS_PER_S        = 1_000_000_000;
  localparam int unsigned SEQ_LIMIT_CYC   = (SEQ_MAX_TIME_S * NS_PER_S) / CLK_PERIOD_NS;
  localparam int          TMR_W           = 26;

  // settling time for the switch synchronisers after reset release
  localparam logic [3:0]  SETTLE_CYC      = 4'h4;

  // register offsets on the read port
  localparam logic [7:0]  PDCS_OFS        = 8'h10;
  localparam logic [7:0]  BER_OFS         = 8'h08;
  localparam int          STF_BIT         = 16;

  // failing-test code values
  localparam logic [7:0]  CODE_IDLE       = 8'h00;
  localparam logic [7:0]  CODE_PASS       = 8'hE0;
  localparam logic [7:0]  CODE_DUP        = 8'hD1;
  localparam logic [7:0]  CODE_MOD        = 8'hF1;
  localparam logic [7:0]  CODE_NODE       = 8'hF2;
  localparam logic [7:0]  CODE_QUIET      = 8'hF3;
  localparam logic [7:0]  CODE_TIMEOUT    = 8'hEF;

  // test numbering: first and last internal hardware test
  localparam logic [4:0]  FIRST_TEST      = 5'h01;
  localparam logic [4:0]  LAST_TEST       = 5'h11;

  // cluster timing switch fields and their legal settings
  localparam int          QSLOT_LSB       = 0;
  localparam int          MOD_LSB         = 3;
  localparam logic [2:0]  QUIET_REQ       = 3'h2;
  localparam logic [2:0]  MOD_SW_16       = 3'h1;
  localparam logic [2:0]  MOD_SW_32       = 3'h2;
  localparam logic [7:0]  NODE_CNT_16     = 8'h10;
  localparam logic [7:0]  NODE_CNT_32     = 8'h20;

  // all switch packs travel together
  typedef struct packed {
    logic [7:0] node;
    logic [7:0] dup;
    logic [5:0] timing;
  } psts_sw_t;

  // sequencer states
  typedef enum logic [2:0] {
    ST_SETTLE,
    ST_LAUNCH,
    ST_WAIT,
    ST_CHECK,
    ST_PASS,
    ST_FAIL
  } psts_state_t;

endpackage : psts_pkg

// [logic/psts_self_test.sv]
// Overview of operation
// - sequence starts by itself after power-up or adapter reset, no host command
// - tests run strictly in order; each starts only after all earlier ones passed
// - seventeen tests from ALU checks up to link maintenance loopback as step 17
// - whole sequence completes in under one second after start
// - pass LED lights on full pass and stays dark on any failure
// - self-test-failed bit 16 of bus error register at 08 cleared on pass, set on fail
// - node address and duplicate address switches differing gives code D1
// - arbitration modulus other than 16 or 32 gives code F1
// - node address not below node count gives code F2
// - quiet slot time setting other than required value gives code F3
// - full pass leaves code e0 in the failing-test code field
`timescale 1ns/1ps

module psts_self_test #(
  parameter int unsigned SEQ_LIMIT = psts_pkg::SEQ_LIMIT_CYC
) (
  input  wire logic        CLK_SYS_IN,
  input  wire logic        RST_IN,
  input  wire logic        CE_IN,
  input  wire logic [7:0]  NODE_SW_IN,
  input  wire logic [7:0]  DUP_SW_IN,
  input  wire logic [5:0]  TIMING_SW_IN,
  input  wire logic        TEST_DONE_IN,
  input  wire logic        TEST_PASS_IN,
  input  wire logic        RD_EN_IN,
  input  wire logic [7:0]  RD_ADDR_IN,
  output logic             TEST_START_OUT,
  output logic [4:0]       TEST_NUM_OUT,
  output logic             BUSY_OUT,
  output logic             PASS_LED_OUT,
  output logic             RD_VALID_OUT,
  output logic [31:0]      RD_DATA_OUT
);

  psts_pkg::psts_sw_t    sw_pin;
  psts_pkg::psts_sw_t    sw_s1_q;
  psts_pkg::psts_sw_t    sw_s2_q;
  psts_pkg::psts_sw_t    sw_s3_q;
  psts_pkg::psts_sw_t    sw_q;
  psts_pkg::psts_state_t state_q;
  psts_pkg::psts_state_t state_d;
  logic [4:0]            test_q;
  logic [4:0]            test_d;
  logic [7:0]            code_q;
  logic [7:0]            code_d;
  logic                  stf_q;
  logic                  stf_d;
  logic                  led_q;
  logic                  led_d;
  logic                  start_q;
  logic                  start_d;
  logic                  busy_q;
  logic                  busy_d;
  logic [3:0]            settle_q;
  logic [psts_pkg::TMR_W-1:0] tmr_q;
  logic                  rd_valid_q;
  logic [31:0]           rd_data_q;
  logic [31:0]           rd_data_d;

  // switch fields and configuration checks
  wire logic [2:0] mod_sel   = sw_q.timing[psts_pkg::MOD_LSB +: 3];
  wire logic [2:0] quiet_sel = sw_q.timing[psts_pkg::QSLOT_LSB +: 3];
  wire logic       mod_ok    = (mod_sel == psts_pkg::MOD_SW_16) ||
                               (mod_sel == psts_pkg::MOD_SW_32);
  wire logic [7:0] node_cnt  = (mod_sel == psts_pkg::MOD_SW_32) ?
                               psts_pkg::NODE_CNT_32 : psts_pkg::NODE_CNT_16;
  wire logic       dup_bad   = (sw_q.node != sw_q.dup);
  wire logic       node_bad  = (sw_q.node >= node_cnt);
  wire logic       quiet_bad = (quiet_sel != psts_pkg::QUIET_REQ);
  wire logic [7:0] cfg_code  = dup_bad   ? psts_pkg::CODE_DUP   :
                               !mod_ok   ? psts_pkg::CODE_MOD   :
                               node_bad  ? psts_pkg::CODE_NODE  :
                               quiet_bad ? psts_pkg::CODE_QUIET :
                               psts_pkg::CODE_PASS;

  // sequence watchdog: whole run must end before the limit
  wire logic       timeout   = (tmr_q == psts_pkg::TMR_W'(SEQ_LIMIT - 1));
  wire logic       running   = (state_q != psts_pkg::ST_PASS) &&
                               (state_q != psts_pkg::ST_FAIL);
  wire logic       fin_d     = (state_d == psts_pkg::ST_PASS) ||
                               (state_d == psts_pkg::ST_FAIL);

  // register read decode; unmapped offsets read zero
  wire logic [31:0] ber_word  = 32'(stf_q) << psts_pkg::STF_BIT;
  wire logic [31:0] pdcs_word = {24'h00_0000, code_q};
  assign rd_data_d = (RD_ADDR_IN == psts_pkg::BER_OFS)  ? ber_word  :
                     (RD_ADDR_IN == psts_pkg::PDCS_OFS) ? pdcs_word :
                     32'h0000_0000;

  assign sw_pin = '{node: NODE_SW_IN, dup: DUP_SW_IN, timing: TIMING_SW_IN};

  // three-stage switch synchroniser; value taken once stages two and three agree
  always_ff @(posedge CLK_SYS_IN)
  begin
    if (RST_IN)
    begin
      sw_s1_q <= '0;
      sw_s2_q <= '0;
      sw_s3_q <= '0;
      sw_q    <= '0;
    end
    else if (CE_IN)
    begin
      sw_s1_q <= sw_pin;
      sw_s2_q <= sw_s1_q;
      sw_s3_q <= sw_s2_q;
      if (sw_s2_q == sw_s3_q)
        sw_q <= sw_s3_q;
    end
  end

  // sequencer next-state logic
  always_comb
  begin
    state_d = state_q;
    test_d  = test_q;
    code_d  = code_q;
    stf_d   = stf_q;
    led_d   = led_q;
    start_d = 1'b0;
    case (state_q)
      psts_pkg::ST_SETTLE:
      begin
        // no host command: run begins once switches have settled
        if (settle_q == psts_pkg::SETTLE_CYC)
        begin
          state_d = psts_pkg::ST_LAUNCH;
          test_d  = psts_pkg::FIRST_TEST;
        end
      end
      psts_pkg::ST_LAUNCH:
      begin
        start_d = 1'b1;
        code_d  = {3'h0, test_q};        // code field tracks the test in progress
        state_d = psts_pkg::ST_WAIT;
      end
      psts_pkg::ST_WAIT:
      begin
        if (timeout)
        begin
          state_d = psts_pkg::ST_FAIL;
          code_d  = psts_pkg::CODE_TIMEOUT;
          stf_d   = 1'b1;
          led_d   = 1'b0;
        end
        else if (TEST_DONE_IN && !TEST_PASS_IN)
        begin
          state_d = psts_pkg::ST_FAIL;   // code keeps failing test number
          stf_d   = 1'b1;
          led_d   = 1'b0;
        end
        else if (TEST_DONE_IN && (test_q == psts_pkg::LAST_TEST))
          state_d = psts_pkg::ST_CHECK;
        else if (TEST_DONE_IN)
        begin
          test_d  = test_q + 5'h01;      // next test only after a pass
          state_d = psts_pkg::ST_LAUNCH;
        end
      end
      psts_pkg::ST_CHECK:
      begin
        if (timeout || (cfg_code != psts_pkg::CODE_PASS))
        begin
          state_d = psts_pkg::ST_FAIL;
          code_d  = timeout ? psts_pkg::CODE_TIMEOUT : cfg_code;
          stf_d   = 1'b1;
          led_d   = 1'b0;
        end
        else
        begin
          state_d = psts_pkg::ST_PASS;
          code_d  = psts_pkg::CODE_PASS;
          stf_d   = 1'b0;
          led_d   = 1'b1;
        end
      end
      psts_pkg::ST_PASS:
        state_d = psts_pkg::ST_PASS;
      psts_pkg::ST_FAIL:
        state_d = psts_pkg::ST_FAIL;     // stopped until next reset
      default:
        state_d = psts_pkg::ST_SETTLE;
    endcase
  end

  assign busy_d = !fin_d;

  // sequencer state registers
  always_ff @(posedge CLK_SYS_IN)
  begin
    if (RST_IN)
    begin
      state_q <= psts_pkg::ST_SETTLE;
      test_q  <= 5'h00;
      code_q  <= psts_pkg::CODE_IDLE;
      stf_q   <= 1'b0;
      led_q   <= 1'b0;
      start_q <= 1'b0;
      busy_q  <= 1'b1;
    end
    else if (CE_IN)
    begin
      state_q <= state_d;
      test_q  <= test_d;
      code_q  <= code_d;
      stf_q   <= stf_d;
      led_q   <= led_d;
      start_q <= start_d;
      busy_q  <= busy_d;
    end
  end

  // settle counter and sequence watchdog
  always_ff @(posedge CLK_SYS_IN)
  begin
    if (RST_IN)
    begin
      settle_q <= 4'h0;
      tmr_q    <= '0;
    end
    else if (CE_IN)
    begin
      if (state_q == psts_pkg::ST_SETTLE)
        settle_q <= settle_q + 4'h1;
      if (running && !timeout)
        tmr_q <= tmr_q + psts_pkg::TMR_W'(1);
    end
  end

  // register read port: answer one cycle after the strobe
  always_ff @(posedge CLK_SYS_IN)
  begin
    if (RST_IN)
    begin
      rd_valid_q <= 1'b0;
      rd_data_q  <= 32'h0000_0000;
    end
    else if (CE_IN)
    begin
      rd_valid_q <= RD_EN_IN;
      if (RD_EN_IN)
        rd_data_q <= rd_data_d;
    end
  end

  assign TEST_START_OUT = start_q;
  assign TEST_NUM_OUT   = test_q;
  assign BUSY_OUT       = busy_q;
  assign PASS_LED_OUT   = led_q;
  assign RD_VALID_OUT   = rd_valid_q;
  assign RD_DATA_OUT    = rd_data_q;

  // checks
  default clocking cb @(posedge CLK_SYS_IN);
  endclocking
  default disable iff (RST_IN);

  chk_auto_start: assert property (
    $fell(RST_IN) ##0 CE_IN [*6] |=> TEST_START_OUT && (TEST_NUM_OUT == psts_pkg::FIRST_TEST))
    else $error("self-test did not start by itself after reset");

  chk_step_order: assert property (
    (state_q == psts_pkg::ST_WAIT) && CE_IN && TEST_DONE_IN && TEST_PASS_IN && !timeout &&
    (test_q != psts_pkg::LAST_TEST)
    |=> (state_q == psts_pkg::ST_LAUNCH) && (test_q == $past(test_q) + 5'h01))
    else $error("passed test not followed by the next test");

  chk_fail_halts: assert property (
    (state_q == psts_pkg::ST_WAIT) && CE_IN && TEST_DONE_IN && !TEST_PASS_IN && !timeout
    |=> (state_q == psts_pkg::ST_FAIL) ##1 !TEST_START_OUT)
    else $error("test launched after a failure");

  chk_last_test: assert property (
    (state_q == psts_pkg::ST_CHECK) |-> (test_q == psts_pkg::LAST_TEST))
    else $error("switch checks reached before test 17");

  chk_run_bound: assert property (
    running |-> (tmr_q < psts_pkg::TMR_W'(SEQ_LIMIT)))
    else $error("sequence watchdog overran its limit");

  chk_led_pass: assert property (
    PASS_LED_OUT |-> (state_q == psts_pkg::ST_PASS) && !stf_q)
    else $error("pass LED lit without a full pass");

  chk_stf_fail: assert property (
    (state_q == psts_pkg::ST_FAIL) |-> stf_q && !PASS_LED_OUT)
    else $error("failed flag not set on failure");

  chk_dup_code: assert property (
    (state_q == psts_pkg::ST_CHECK) && CE_IN && !timeout && dup_bad
    |=> (state_q == psts_pkg::ST_FAIL) && (code_q == psts_pkg::CODE_DUP))
    else $error("address mismatch not reported as D1");

  chk_mod_code: assert property (
    (state_q == psts_pkg::ST_CHECK) && CE_IN && !timeout && !dup_bad && !mod_ok
    |=> (code_q == psts_pkg::CODE_MOD))
    else $error("bad modulus not reported as F1");

  chk_node_code: assert property (
    (state_q == psts_pkg::ST_CHECK) && CE_IN && !timeout && !dup_bad && mod_ok && node_bad
    |=> (code_q == psts_pkg::CODE_NODE))
    else $error("node address too high not reported as F2");

  chk_quiet_code: assert property (
    (state_q == psts_pkg::ST_CHECK) && CE_IN && !timeout && !dup_bad && mod_ok &&
    !node_bad && quiet_bad |=> (code_q == psts_pkg::CODE_QUIET))
    else $error("bad quiet slot not reported as F3");

  chk_pass_code: assert property (
    (state_q == psts_pkg::ST_PASS) |-> (code_q == psts_pkg::CODE_PASS) && !stf_q)
    else $error("pass without code e0");

  chk_fail_hold: assert property (
    (state_q == psts_pkg::ST_FAIL) |=> (state_q == psts_pkg::ST_FAIL) && $stable(code_q))
    else $error("failing code changed before reset");

endmodule : psts_self_test

// [verification/psts_engine_model.sv]
`timescale 1ns/1ps

// stand-in for the internal test engine: answers each start pulse after a short delay, except for the stalled test
module psts_engine_model (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       ce_in,
  input  wire logic       start_in,
  input  wire logic [4:0] num_in,
  input  wire logic [4:0] fail_at_in,
  input  wire logic [4:0] stall_at_in,
  input  wire logic [1:0] dly_in,
  output logic            done_out,
  output logic            pass_out,
  output int              last_out,
  output int              order_errs_out
);
  // waits for the next edge at which the clock enable lets the adapter's state move
  task automatic step;
    do
      @(posedge clk_in);
    while (ce_in !== 1'b1);
  endtask : step

  // one test at a time; a stalled test never answers, so only the watchdog ends it
  initial
  begin
    done_out = 1'b0;
    pass_out = 1'b1;
    last_out = 0;
    order_errs_out = 0;
    forever
    begin
      step();
      if (rst_in)
        last_out = 0; // forget the sequence position on adapter reset
      else if (start_in === 1'b1)
      begin
        if (int'(num_in) != last_out + 1)
          order_errs_out++;
        last_out = int'(num_in);
        if (num_in != stall_at_in)
        begin
          repeat (int'(dly_in) + 1) step();
          #1;
          done_out = 1'b1;
          pass_out = (last_out != int'(fail_at_in));
          step(); // done held until an enabled edge takes it
          #1;
          done_out = 1'b0;
          pass_out = ~pass_out; // pass level is meaningless outside a done pulse
        end
      end
    end
  end
endmodule : psts_engine_model

// [verification/tb.sv]
`timescale 1ns/1ps

module tb;
  localparam int unsigned LIMIT = 200;
  logic        clk, rst, ce, rd_en, t_done, t_pass, t_start, busy, led, rd_valid;
  logic [7:0]  node_sw, dup_sw, rd_addr;
  logic [5:0]  timing_sw;
  logic [4:0]  t_num, fail_at, stall_at;
  logic [1:0]  dly;
  logic [31:0] rd_data;
  int          last_num, order_errs, fails, n_checks, seed, cyc;

  psts_self_test #(.SEQ_LIMIT(LIMIT)) psts_self_test_i (
    .CLK_SYS_IN(clk), .RST_IN(rst), .CE_IN(ce), .NODE_SW_IN(node_sw), .DUP_SW_IN(dup_sw),
    .TIMING_SW_IN(timing_sw), .TEST_DONE_IN(t_done), .TEST_PASS_IN(t_pass),
    .RD_EN_IN(rd_en), .RD_ADDR_IN(rd_addr), .TEST_START_OUT(t_start), .TEST_NUM_OUT(t_num),
    .BUSY_OUT(busy), .PASS_LED_OUT(led), .RD_VALID_OUT(rd_valid), .RD_DATA_OUT(rd_data));

  psts_engine_model psts_engine_model_i (
    .clk_in(clk), .rst_in(rst), .ce_in(ce), .start_in(t_start), .num_in(t_num),
    .fail_at_in(fail_at),
    .stall_at_in(stall_at), .dly_in(dly), .done_out(t_done), .pass_out(t_pass),
    .last_out(last_num), .order_errs_out(order_errs));

  // 40 MHz system clock
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // compare one value and count it
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : give_verdict

  // one read strobe, answer expected on the following edge
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rd_en = 1'b1;
    rd_addr = a;
    @(posedge clk);
    #1 rd_en = 1'b0;
    rd_addr = $random(seed);
    chk("rd_valid", {31'h0, rd_valid}, 32'h1);
    chk("rd_data", rd_data, e);
    @(posedge clk);
    #1;
  endtask : rd

  // reference outcome from the switch settings and the injected engine behaviour
  function automatic int exp_code(input int n, input int d, input int t, input int f,
                                  input int s);
    int cnt;
    cnt = ((t >> 3) == 1) ? 16 : (((t >> 3) == 2) ? 32 : 0);
    if (s != 0) return 8'hEF;
    if (f != 0) return f;
    if (n != d) return 8'hD1;
    if (cnt == 0) return 8'hF1;
    if (n >= cnt) return 8'hF2;
    if ((t & 7) != 2) return 8'hF3;
    return 8'hE0;
  endfunction : exp_code

  // reset the adapter, let the sequence run by itself and read back its outcome
  task automatic run(input int n, input int d, input int t, input int f, input int s);
    int code;
    int last;
    code = exp_code(n, d, t, f, s);
    last = (f != 0) ? f : ((s != 0) ? s : 17);
    node_sw = n[7:0];
    dup_sw = d[7:0];
    timing_sw = t[5:0];
    fail_at = f[4:0];
    stall_at = s[4:0];
    dly = $random(seed);
    rst = 1'b1;
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
    cyc = 0;
    // random clock-enable gaps; only enabled edges count towards the run time
    while (busy !== 1'b0 && cyc < 400)
    begin
      ce = (($random(seed) & 7) != 0);
      @(posedge clk);
      #1;
      if (ce)
        cyc++;
    end
    if (s == 0)
      chk("run_time", {31'h0, cyc < LIMIT}, 32'h1);
    chk("pass_led", {31'h0, led}, {31'h0, code == 8'hE0});
    rd(8'h10, code);
    rd(8'h08, (code == 8'hE0) ? 32'h0 : 32'h0001_0000);
    rd(8'h0C, 32'h0);
    repeat (6) @(posedge clk);
    #1;
    chk("last_test", last_num, last);
    chk("order_errs", order_errs, 32'h0);
    chk("busy", {31'h0, busy}, 32'h0);
    rd(8'h10, code);
    $display("test done: switches %h %h %h code %h", n, d, t, code);
  endtask : run

  // give up if the sequences hang
  initial
  begin
    #(25 * 30000);
    fails++;
    give_verdict();
  end

  // main sequence
  initial
  begin
    int n;
    seed = 32'h37a9;
    fails = 0;
    n_checks = 0;
    rst = 1'b1;
    ce = 1'b1;
    rd_en = 1'b0;
    rd_addr = 8'h00;
    node_sw = 8'h00;
    dup_sw = 8'h00;
    timing_sw = 6'h00;
    fail_at = 5'h00;
    stall_at = 5'h00;
    dly = 2'h0;
    @(posedge clk);
    #1;
    run(5, 5, 6'h0A, 0, 0);
    run(31, 31, 6'h12, 0, 0);
    run(5, 6, 6'h0A, 0, 0);
    run(5, 5, 6'h02, 0, 0);
    run(5, 5, 6'h3A, 0, 0);
    run(16, 16, 6'h0A, 0, 0);
    run(32, 32, 6'h12, 0, 0);
    run(5, 5, 6'h0B, 0, 0);
    run(5, 5, 6'h0A, 1, 0);
    run(5, 5, 6'h0A, 17, 0);
    run(5, 5, 6'h0A, 0, 9);
    repeat (6)
    begin
      n = $unsigned($random(seed)) % 40;
      run(n, ($random(seed) & 1) ? n : n ^ 1, $unsigned($random(seed)) % 64,
          (($random(seed) & 3) == 0) ? 1 + $unsigned($random(seed)) % 17 : 0,
          0);
    end
    give_verdict();
  end
endmodule : tb
